/* oslf_pkg.sv */
// Shared constants for the output, status and loss filter register bank
package oslf_pkg;

    localparam int unsigned ADDR_W = 7;
    localparam int unsigned DATA_W = 16;

    // Register offsets
    localparam logic [6:0] OFF_DRIVER_CFG   = 7'h04;
    localparam logic [6:0] OFF_QUIET_CTRL   = 7'h05;
    localparam logic [6:0] OFF_INPUT_STATUS = 7'h06;
    localparam logic [6:0] OFF_LOSS_DELAYS  = 7'h07;
    localparam logic [6:0] OFF_LOSS_CTRL    = 7'h08;

    // Field positions
    localparam int unsigned SWING_LSB       = 11;
    localparam int unsigned SWING_MSB       = 14;
    localparam int unsigned SWING_OVR_BIT   = 10;
    localparam int unsigned TAP_DELAY_BIT   = 9;
    localparam int unsigned STRENGTH_LSB    = 6;
    localparam int unsigned STRENGTH_MSB    = 8;
    localparam int unsigned EMPH_EN_BIT     = 1;
    localparam int unsigned POWERDOWN_BIT   = 2;
    localparam int unsigned AUTO_QUIET_BIT  = 1;
    localparam int unsigned MUTE_BIT        = 0;
    localparam int unsigned REACH_LSB       = 8;
    localparam int unsigned REACH_MSB       = 15;
    localparam int unsigned RATE_LSB        = 1;
    localparam int unsigned RATE_MSB        = 3;
    localparam int unsigned PRESENT_BIT     = 0;
    localparam int unsigned ASSERT_DLY_LSB  = 8;
    localparam int unsigned ASSERT_DLY_MSB  = 15;
    localparam int unsigned RELEASE_DLY_LSB = 0;
    localparam int unsigned RELEASE_DLY_MSB = 7;
    localparam int unsigned BYPASS_BIT      = 0;

    // Reset and fixed values
    localparam logic [3:0] SWING_RST       = 4'hb;
    localparam logic [3:0] SWING_DEFAULT   = 4'hb;
    localparam logic [7:0] ASSERT_DLY_RST  = 8'h02;
    localparam logic [7:0] RELEASE_DLY_RST = 8'h01;
    localparam logic [7:0] REACH_RST       = 8'h00;
    localparam logic [7:0] REACH_MAX       = 8'hef;
    localparam logic [2:0] RATE_RST        = 3'h1;
    localparam logic [2:0] RATE_MAX        = 3'h4;
    localparam logic [2:0] STRENGTH_OFF    = 3'h0;

    // Tap delay encodings: 0 selects 100 ps, 1 selects 200 ps
    localparam int unsigned TAP_SHORT_PS = 100;
    localparam int unsigned TAP_LONG_PS  = 200;

    // Loss filter step timing
    localparam int unsigned CLK_PERIOD_NS    = 8;
    localparam int unsigned ASSERT_STEP_NS   = 25900;
    localparam int unsigned RELEASE_STEP_NS  = 6600000;
    localparam int unsigned ASSERT_STEP_CYC  = ASSERT_STEP_NS / CLK_PERIOD_NS;
    localparam int unsigned RELEASE_STEP_CYC = RELEASE_STEP_NS / CLK_PERIOD_NS;
    localparam int unsigned PRESCALE_W       = 20;

    typedef enum logic [1:0] {
        ST_CLEAR,
        ST_ASSERT_WAIT,
        ST_LOST,
        ST_RELEASE_WAIT
    } oslf_state_e;

endpackage

/* oslf_sync.sv */
// Two-flop synchroniser for detector levels
`timescale 1ns/100ps
module oslf_sync #(
    parameter int unsigned WIDTH = 2
) (
    input  wire logic             ref_clk_i,
    input  wire logic             srst_i,
    input  wire logic [WIDTH-1:0] async_i,
    output logic      [WIDTH-1:0] sync_o
);
    logic [WIDTH-1:0] meta_q;
    logic [WIDTH-1:0] sync_q;

    always_ff @(posedge ref_clk_i) begin
        if (srst_i) begin
            meta_q <= '0;
            sync_q <= '0;
        end else begin
            meta_q <= async_i;
            sync_q <= meta_q;
        end
    end

    assign sync_o = sync_q;
endmodule

/* oslf_step_timer.sv */
// Step counter for the loss filter delays
`timescale 1ns/100ps
module oslf_step_timer #(
    parameter int unsigned RELEASE_STEP_CYC = oslf_pkg::RELEASE_STEP_CYC
) (
    input  wire logic       ref_clk_i,
    input  wire logic       srst_i,
    input  wire logic       run_i,
    input  wire logic       long_step_i,
    output logic      [7:0] steps_o
);
    localparam int unsigned PW = oslf_pkg::PRESCALE_W;
    localparam logic [PW-1:0] SHORT_LAST =
        PW'(oslf_pkg::ASSERT_STEP_CYC - 1);
    localparam logic [PW-1:0] LONG_LAST = PW'(RELEASE_STEP_CYC - 1);

    logic [PW-1:0] pre_q;
    logic [7:0]    steps_q;
    logic [PW-1:0] last;

    assign last = long_step_i ? LONG_LAST : SHORT_LAST;

    // Both counters restart whenever a wait is abandoned
    always_ff @(posedge ref_clk_i) begin
        if (srst_i || !run_i) begin
            pre_q   <= '0;
            steps_q <= 8'h00;
        end else if (pre_q >= last) begin
            pre_q <= '0;
            if (steps_q != 8'hff) begin
                steps_q <= steps_q + 8'h01;
            end
        end else begin
            pre_q <= pre_q + PW'(1);
        end
    end

    assign steps_o = steps_q;
endmodule

/* oslf_regs.sv */
// Output driver, status and loss filter register bank with loss filter
`timescale 1ns/100ps
//
// Behaviour
// - Amplitude code drives the output swing only while override is set.
// - Without override the swing code is fixed at 0xB.
// - Tap delay bit picks 100 ps (0) or 200 ps (1) when enabled.
// - Emphasis strength applies only while emphasis is enabled.
// - Emphasis enable turns delay and strength on or off; resets 0.
// - Powerdown bit at 1 powers the output buffer down.
// - Auto-quiet mutes the output whenever carrier loss is asserted.
// - Mute holds both output halves static at opposite levels.
// - Cable reach estimate reads 8 bits, 2.5 m steps, up to EFh.
// - Rate code reads 000..100 by detected rate; resets to 001.
// - Signal present reads 1 while a qualified input is present.
// - Loss assert delay counts 25.9 us steps; resets to 02h.
// - Loss release delay counts 6.6 ms steps; resets to 01h.
// - Filter bypass at 1 disables the carrier loss filter.
// - Interrupt pin shows the filtered carrier loss.
module oslf_regs #(
    parameter int unsigned RELEASE_STEP_CYC = oslf_pkg::RELEASE_STEP_CYC
) (
    input  wire logic        ref_clk_i,
    input  wire logic        srst_i,
    // Register access port of the host interface
    input  wire logic [6:0]  reg_addr_i,
    input  wire logic        reg_wr_i,
    input  wire logic [15:0] reg_wdata_i,
    input  wire logic        reg_rd_i,
    output logic      [15:0] reg_rdata_o,
    output logic             reg_rvalid_o,
    // Detector inputs
    input  wire logic        raw_loss_i,
    input  wire logic        signal_present_i,
    input  wire logic [7:0]  cable_reach_i,
    input  wire logic [2:0]  rate_code_i,
    // Output stage controls
    output logic      [3:0]  swing_code_o,
    output logic             emph_en_o,
    output logic             emph_tap_delay_o,
    output logic      [2:0]  emph_strength_o,
    output logic             driver_powerdown_o,
    output logic             mute_o,
    output logic             carrier_loss_o,
    output logic             int_o
);

    // Stored register fields
    logic [3:0]  swing_q;
    logic        swing_ovr_q;
    logic        tap_delay_q;
    logic [2:0]  strength_q;
    logic        emph_en_q;
    logic        powerdown_q;
    logic        auto_quiet_q;
    logic        mute_q;
    logic [7:0]  assert_dly_q;
    logic [7:0]  release_dly_q;
    logic        bypass_q;

    // Captured status
    logic [7:0]  reach_q;
    logic [2:0]  rate_q;
    logic        present_q;

    // Read port
    logic [15:0] rdata_q;
    logic        rvalid_q;
    logic [15:0] rdata_d;

    // Synchronised detector levels
    logic [1:0]  det_sync;
    logic        loss_s;
    logic        present_s;

    // Loss filter
    oslf_pkg::oslf_state_e state_q;
    oslf_pkg::oslf_state_e state_d;
    logic        loss_q;
    logic        wait_run;
    logic [7:0]  steps;

    // Registered output stage
    logic [3:0]  swing_out_q;
    logic        emph_en_out_q;
    logic        tap_out_q;
    logic [2:0]  strength_out_q;
    logic        powerdown_out_q;
    logic        mute_out_q;

    function automatic logic wr_hit(
        input logic       wr,
        input logic [6:0] addr,
        input logic [6:0] off
    );
        return wr && (addr == off);
    endfunction

    function automatic logic filt_lost(input oslf_pkg::oslf_state_e st);
        return (st == oslf_pkg::ST_LOST) ||
               (st == oslf_pkg::ST_RELEASE_WAIT);
    endfunction

    // Loss and presence detectors are asynchronous to this clock
    oslf_sync #(
        .WIDTH (2)
    ) u_det_sync (
        .ref_clk_i (ref_clk_i),
        .srst_i    (srst_i),
        .async_i   ({raw_loss_i, signal_present_i}),
        .sync_o    (det_sync)
    );

    assign loss_s    = det_sync[1];
    assign present_s = det_sync[0];

    // Output driver configuration
    always_ff @(posedge ref_clk_i) begin
        if (srst_i) begin
            swing_q     <= oslf_pkg::SWING_RST;
            swing_ovr_q <= 1'b0;
            tap_delay_q <= 1'b0;
            strength_q  <= 3'h0;
            emph_en_q   <= 1'b0;
        end else if (wr_hit(reg_wr_i, reg_addr_i,
                            oslf_pkg::OFF_DRIVER_CFG)) begin
            swing_q <= reg_wdata_i[oslf_pkg::SWING_MSB:oslf_pkg::SWING_LSB];
            swing_ovr_q <= reg_wdata_i[oslf_pkg::SWING_OVR_BIT];
            tap_delay_q <= reg_wdata_i[oslf_pkg::TAP_DELAY_BIT];
            strength_q  <=
                reg_wdata_i[oslf_pkg::STRENGTH_MSB:oslf_pkg::STRENGTH_LSB];
            emph_en_q   <= reg_wdata_i[oslf_pkg::EMPH_EN_BIT];
        end
    end

    // Output disable and mute control
    always_ff @(posedge ref_clk_i) begin
        if (srst_i) begin
            powerdown_q  <= 1'b0;
            auto_quiet_q <= 1'b0;
            mute_q       <= 1'b0;
        end else if (wr_hit(reg_wr_i, reg_addr_i,
                            oslf_pkg::OFF_QUIET_CTRL)) begin
            powerdown_q  <= reg_wdata_i[oslf_pkg::POWERDOWN_BIT];
            auto_quiet_q <= reg_wdata_i[oslf_pkg::AUTO_QUIET_BIT];
            mute_q       <= reg_wdata_i[oslf_pkg::MUTE_BIT];
        end
    end

    // Loss filter delays
    always_ff @(posedge ref_clk_i) begin
        if (srst_i) begin
            assert_dly_q  <= oslf_pkg::ASSERT_DLY_RST;
            release_dly_q <= oslf_pkg::RELEASE_DLY_RST;
        end else if (wr_hit(reg_wr_i, reg_addr_i,
                            oslf_pkg::OFF_LOSS_DELAYS)) begin
            assert_dly_q  <=
                reg_wdata_i[oslf_pkg::ASSERT_DLY_MSB:oslf_pkg::ASSERT_DLY_LSB];
            release_dly_q <= reg_wdata_i[oslf_pkg::RELEASE_DLY_MSB:
                                         oslf_pkg::RELEASE_DLY_LSB];
        end
    end

    // Loss filter control
    always_ff @(posedge ref_clk_i) begin
        if (srst_i) begin
            bypass_q <= 1'b0;
        end else if (wr_hit(reg_wr_i, reg_addr_i,
                            oslf_pkg::OFF_LOSS_CTRL)) begin
            bypass_q <= reg_wdata_i[oslf_pkg::BYPASS_BIT];
        end
    end

    // Status capture; writes to the status offset land nowhere
    always_ff @(posedge ref_clk_i) begin
        if (srst_i) begin
            reach_q   <= oslf_pkg::REACH_RST;
            rate_q    <= oslf_pkg::RATE_RST;
            present_q <= 1'b0;
        end else begin
            // Estimates past the top of the scale read as the maximum
            if (cable_reach_i > oslf_pkg::REACH_MAX) begin
                reach_q <= oslf_pkg::REACH_MAX;
            end else begin
                reach_q <= cable_reach_i;
            end
            // Invalid rate codes keep the last valid reading
            if (rate_code_i <= oslf_pkg::RATE_MAX) begin
                rate_q <= rate_code_i;
            end
            present_q <= present_s;
        end
    end

    // Read data; only documented fields read back, the rest as zero
    always_comb begin
        rdata_d = 16'h0000;
        case (reg_addr_i)
            oslf_pkg::OFF_DRIVER_CFG: begin
                rdata_d[oslf_pkg::SWING_MSB:oslf_pkg::SWING_LSB] = swing_q;
                rdata_d[oslf_pkg::SWING_OVR_BIT] = swing_ovr_q;
                rdata_d[oslf_pkg::TAP_DELAY_BIT] = tap_delay_q;
                rdata_d[oslf_pkg::STRENGTH_MSB:oslf_pkg::STRENGTH_LSB] =
                    strength_q;
                rdata_d[oslf_pkg::EMPH_EN_BIT] = emph_en_q;
            end
            oslf_pkg::OFF_QUIET_CTRL: begin
                rdata_d[oslf_pkg::POWERDOWN_BIT]  = powerdown_q;
                rdata_d[oslf_pkg::AUTO_QUIET_BIT] = auto_quiet_q;
                rdata_d[oslf_pkg::MUTE_BIT]       = mute_q;
            end
            oslf_pkg::OFF_INPUT_STATUS: begin
                rdata_d[oslf_pkg::REACH_MSB:oslf_pkg::REACH_LSB] = reach_q;
                rdata_d[oslf_pkg::RATE_MSB:oslf_pkg::RATE_LSB] = rate_q;
                rdata_d[oslf_pkg::PRESENT_BIT] = present_q;
            end
            oslf_pkg::OFF_LOSS_DELAYS: begin
                rdata_d[oslf_pkg::ASSERT_DLY_MSB:oslf_pkg::ASSERT_DLY_LSB] =
                    assert_dly_q;
                rdata_d[oslf_pkg::RELEASE_DLY_MSB:oslf_pkg::RELEASE_DLY_LSB] =
                    release_dly_q;
            end
            oslf_pkg::OFF_LOSS_CTRL: begin
                rdata_d[oslf_pkg::BYPASS_BIT] = bypass_q;
            end
            default: begin
                rdata_d = 16'h0000;
            end
        endcase
    end

    always_ff @(posedge ref_clk_i) begin
        if (srst_i) begin
            rdata_q  <= 16'h0000;
            rvalid_q <= 1'b0;
        end else begin
            rvalid_q <= reg_rd_i;
            if (reg_rd_i) begin
                rdata_q <= rdata_d;
            end
        end
    end

    // Carrier loss filter
    always_comb begin
        state_d = state_q;
        if (bypass_q) begin
            // Raw loss passes straight through
            state_d = loss_s ? oslf_pkg::ST_LOST
                             : oslf_pkg::ST_CLEAR;
        end else begin
            case (state_q)
                oslf_pkg::ST_CLEAR: begin
                    if (loss_s) begin
                        state_d = oslf_pkg::ST_ASSERT_WAIT;
                    end
                end
                oslf_pkg::ST_ASSERT_WAIT: begin
                    if (!loss_s) begin
                        state_d = oslf_pkg::ST_CLEAR;
                    end else if (steps >= assert_dly_q) begin
                        state_d = oslf_pkg::ST_LOST;
                    end
                end
                oslf_pkg::ST_LOST: begin
                    if (!loss_s) begin
                        state_d = oslf_pkg::ST_RELEASE_WAIT;
                    end
                end
                oslf_pkg::ST_RELEASE_WAIT: begin
                    if (loss_s) begin
                        state_d = oslf_pkg::ST_LOST;
                    end else if (steps >= release_dly_q) begin
                        state_d = oslf_pkg::ST_CLEAR;
                    end
                end
                default: begin
                    state_d = oslf_pkg::ST_CLEAR;
                end
            endcase
        end
    end

    always_ff @(posedge ref_clk_i) begin
        if (srst_i) begin
            state_q <= oslf_pkg::ST_CLEAR;
            loss_q  <= 1'b0;
        end else begin
            state_q <= state_d;
            loss_q  <= filt_lost(state_d);
        end
    end

    assign wait_run = !bypass_q &&
                      ((state_q == oslf_pkg::ST_ASSERT_WAIT) ||
                       (state_q == oslf_pkg::ST_RELEASE_WAIT));

    oslf_step_timer #(
        .RELEASE_STEP_CYC (RELEASE_STEP_CYC)
    ) u_step_timer (
        .ref_clk_i   (ref_clk_i),
        .srst_i      (srst_i),
        .run_i       (wait_run),
        .long_step_i (state_q == oslf_pkg::ST_RELEASE_WAIT),
        .steps_o     (steps)
    );

    // Output stage settings
    always_ff @(posedge ref_clk_i) begin
        if (srst_i) begin
            swing_out_q     <= oslf_pkg::SWING_DEFAULT;
            emph_en_out_q   <= 1'b0;
            tap_out_q       <= 1'b0;
            strength_out_q  <= oslf_pkg::STRENGTH_OFF;
            powerdown_out_q <= 1'b0;
            mute_out_q      <= 1'b0;
        end else begin
            if (swing_ovr_q) begin
                swing_out_q <= swing_q;
            end else begin
                swing_out_q <= oslf_pkg::SWING_DEFAULT;
            end
            emph_en_out_q <= emph_en_q;
            // Delay and strength are forced off while emphasis is off
            tap_out_q <= emph_en_q & tap_delay_q;
            strength_out_q <= emph_en_q ? strength_q
                                        : oslf_pkg::STRENGTH_OFF;
            powerdown_out_q <= powerdown_q;
            mute_out_q <= mute_q | (auto_quiet_q & loss_q);
        end
    end

    assign reg_rdata_o        = rdata_q;
    assign reg_rvalid_o       = rvalid_q;
    assign swing_code_o       = swing_out_q;
    assign emph_en_o          = emph_en_out_q;
    assign emph_tap_delay_o   = tap_out_q;
    assign emph_strength_o    = strength_out_q;
    assign driver_powerdown_o = powerdown_out_q;
    assign mute_o             = mute_out_q;
    assign carrier_loss_o     = loss_q;
    assign int_o              = loss_q;

endmodule

/* oslf_regs_asserts.sv */
// Concurrent checks on the register bank ports
`timescale 1ns/100ps
module oslf_regs_chk (
    input wire logic        ref_clk_i,
    input wire logic        srst_i,
    input wire logic [6:0]  reg_addr_i,
    input wire logic        reg_wr_i,
    input wire logic [15:0] reg_wdata_i,
    input wire logic        reg_rd_i,
    input wire logic [15:0] reg_rdata_o,
    input wire logic        reg_rvalid_o,
    input wire logic [3:0]  swing_code_o,
    input wire logic        emph_en_o,
    input wire logic        emph_tap_delay_o,
    input wire logic [2:0]  emph_strength_o,
    input wire logic        driver_powerdown_o,
    input wire logic        mute_o,
    input wire logic        carrier_loss_o,
    input wire logic        int_o
);
    default clocking @(posedge ref_clk_i); endclocking
    default disable iff (srst_i);

    logic aq_q;

    // Shadow of the auto-quiet field, stored on the same edge as the bank
    always_ff @(posedge ref_clk_i) begin
        if (srst_i) begin
            aq_q <= 1'b0;
        end else if (reg_wr_i && reg_addr_i == 7'h05) begin
            aq_q <= reg_wdata_i[1];
        end
    end

    sequence s_cfg_wr;
        reg_wr_i && reg_addr_i == 7'h04;
    endsequence

    sequence s_quiet_wr;
        reg_wr_i && reg_addr_i == 7'h05;
    endsequence

    swing_dflt_a: assert property (s_cfg_wr ##0 !reg_wdata_i[10]
        |-> ##2 swing_code_o == 4'hb) else $error("swing not default");
    swing_ovr_a: assert property (s_cfg_wr ##0 reg_wdata_i[10]
        |-> ##2 swing_code_o == $past(reg_wdata_i[14:11], 2))
        else $error("swing override lost");
    emph_en_a: assert property (s_cfg_wr
        |-> ##2 emph_en_o == $past(reg_wdata_i[1], 2))
        else $error("emphasis enable wrong");
    emph_off_a: assert property (!emph_en_o
        |-> emph_tap_delay_o == 1'b0 && emph_strength_o == 3'h0)
        else $error("emphasis active while off");
    pwr_down_a: assert property (s_quiet_wr
        |-> ##2 driver_powerdown_o == $past(reg_wdata_i[2], 2))
        else $error("powerdown wrong");
    mute_set_a: assert property (s_quiet_wr ##0 reg_wdata_i[0]
        |-> ##2 mute_o) else $error("mute not applied");
    auto_quiet_a: assert property (aq_q && carrier_loss_o |=> mute_o)
        else $error("no mute on carrier loss");
    int_loss_a: assert property (int_o == carrier_loss_o)
        else $error("interrupt differs from loss");
    rd_answer_a: assert property (reg_rd_i |=> reg_rvalid_o ##0
        $past(reg_rd_i)) else $error("read not answered");
    rvalid_src_a: assert property (reg_rvalid_o
        |-> $past(reg_rd_i)) else $error("spurious read valid");
    rsvd_zero_a: assert property (reg_rd_i && reg_addr_i == 7'h06
        |=> reg_rdata_o[7:4] == 4'h0) else $error("reserved bits set");
endmodule

bind oslf_regs oslf_regs_chk i_oslf_regs_chk (
    .ref_clk_i, .srst_i, .reg_addr_i, .reg_wr_i, .reg_wdata_i,
    .reg_rd_i, .reg_rdata_o, .reg_rvalid_o, .swing_code_o,
    .emph_en_o, .emph_tap_delay_o, .emph_strength_o,
    .driver_powerdown_o, .mute_o, .carrier_loss_o, .int_o
);

/* oslf_host_model.sv */
// Host controller model driving the register access port
`timescale 1ns/100ps
module oslf_host_model (
    input  wire logic        ref_clk_i,
    output logic      [6:0]  reg_addr_o,
    output logic             reg_wr_o,
    output logic      [15:0] reg_wdata_o,
    output logic             reg_rd_o,
    input  wire logic [15:0] reg_rdata_i,
    input  wire logic        reg_rvalid_i
);
    initial begin
        reg_addr_o  = 7'h00;
        reg_wr_o    = 1'b0;
        reg_wdata_o = 16'h0000;
        reg_rd_o    = 1'b0;
    end

    // Reserved fields of writable registers always go out as zero
    function automatic logic [15:0] keep(logic [6:0] a, logic [15:0] d);
        case (a)
            7'h04: return d & 16'h7fc2;
            7'h05: return d & 16'h0007;
            7'h08: return d & 16'h0001;
            default: return d;
        endcase
    endfunction

    task automatic wr(input logic [6:0] a, input logic [15:0] d);
        @(posedge ref_clk_i);
        reg_addr_o  <= a;
        reg_wdata_o <= keep(a, d);
        reg_wr_o    <= 1'b1;
        @(posedge ref_clk_i);
        reg_wr_o    <= 1'b0;
    endtask

    task automatic rd(input logic [6:0] a, output logic [15:0] d);
        int n;
        @(posedge ref_clk_i);
        reg_addr_o <= a;
        reg_rd_o   <= 1'b1;
        @(posedge ref_clk_i);
        reg_rd_o   <= 1'b0;
        n = 0;
        #1;
        while (reg_rvalid_i !== 1'b1 && n < 4) begin
            @(posedge ref_clk_i);
            #1;
            n++;
        end
        d = (reg_rvalid_i === 1'b1) ? reg_rdata_i : 16'hxxxx;
    endtask
endmodule

/* test_output_status_loss_filter_regs.sv */
// Self-checking bench for the output, status and loss filter registers
`timescale 1ns/100ps
module test_output_status_loss_filter_regs;
    logic        ref_clk_i        = 1'b0;
    logic        srst_i           = 1'b1;
    logic [6:0]  reg_addr_i;
    logic        reg_wr_i;
    logic [15:0] reg_wdata_i;
    logic        reg_rd_i;
    logic [15:0] reg_rdata_o;
    logic        reg_rvalid_o;
    logic        raw_loss_i       = 1'b0;
    logic        signal_present_i = 1'b0;
    logic [7:0]  cable_reach_i    = 8'h00;
    logic [2:0]  rate_code_i      = 3'h1;
    logic [3:0]  swing_code_o;
    logic        emph_en_o;
    logic        emph_tap_delay_o;
    logic [2:0]  emph_strength_o;
    logic        driver_powerdown_o;
    logic        mute_o;
    logic        carrier_loss_o;
    logic        int_o;
    int          n_errors         = 0;
    int          checked          = 0;
    int          cyc              = 0;
    logic [15:0] v;

    always #4 ref_clk_i = ~ref_clk_i;

    oslf_regs #(.RELEASE_STEP_CYC(20)) i_oslf_regs (
        .ref_clk_i, .srst_i, .reg_addr_i, .reg_wr_i, .reg_wdata_i,
        .reg_rd_i, .reg_rdata_o, .reg_rvalid_o, .raw_loss_i,
        .signal_present_i, .cable_reach_i, .rate_code_i, .swing_code_o,
        .emph_en_o, .emph_tap_delay_o, .emph_strength_o,
        .driver_powerdown_o, .mute_o, .carrier_loss_o, .int_o
    );

    oslf_host_model i_oslf_host_model (
        .ref_clk_i    (ref_clk_i),
        .reg_addr_o   (reg_addr_i),
        .reg_wr_o     (reg_wr_i),
        .reg_wdata_o  (reg_wdata_i),
        .reg_rd_o     (reg_rd_i),
        .reg_rdata_i  (reg_rdata_o),
        .reg_rvalid_i (reg_rvalid_o)
    );

    task automatic chk(input string nm, input logic [15:0] e,
                       input logic [15:0] g);
        checked++;
        if (g !== e) begin
            n_errors++;
            $display("BAD %s expected %h seen %h", nm, e, g);
        end
    endtask

    task automatic rchk(input logic [6:0] a, input logic [15:0] e);
        i_oslf_host_model.rd(a, v);
        chk($sformatf("read %h", a), e, v);
    endtask

    task automatic wait_cyc(input int n);
        repeat (n) @(posedge ref_clk_i);
        #1;
    endtask

    task automatic set_loss(input logic l, input int n);
        @(posedge ref_clk_i);
        raw_loss_i <= l;
        wait_cyc(n);
    endtask

    task automatic give_verdict();
        $display("comparisons %0d mismatches %0d", checked, n_errors);
        if (n_errors == 0 && checked > 0) begin
            $display("== PASSED ==");
        end else begin
            $display("== FAILED ==");
        end
        $finish;
    endtask

    // Whole run needs about 4000 cycles
    always @(posedge ref_clk_i) begin
        cyc++;
        if (cyc == 10000) begin
            n_errors++;
            give_verdict();
        end
    end

    initial begin
        repeat (4) @(posedge ref_clk_i);
        srst_i <= 1'b0;
        chk("swing", 16'h000b, {12'h0, swing_code_o});
        rchk(7'h04, 16'h5800);
        rchk(7'h05, 16'h0000);
        rchk(7'h06, 16'h0002);
        rchk(7'h07, 16'h0201);
        rchk(7'h08, 16'h0000);
        $display("test reset done");
        i_oslf_host_model.wr(7'h04, 16'h7fc2);
        wait_cyc(3);
        chk("swing", 16'h000f, {12'h0, swing_code_o});
        chk("emph", 16'h001f, {11'h0, emph_en_o, emph_tap_delay_o,
            emph_strength_o});
        rchk(7'h04, 16'h7fc2);
        i_oslf_host_model.wr(7'h04, 16'h0542);
        wait_cyc(3);
        chk("swing", 16'h0000, {12'h0, swing_code_o});
        chk("emph", 16'h0015, {11'h0, emph_en_o, emph_tap_delay_o,
            emph_strength_o});
        i_oslf_host_model.wr(7'h04, 16'h7bc0);
        wait_cyc(3);
        chk("swing", 16'h000b, {12'h0, swing_code_o});
        chk("emph", 16'h0000, {11'h0, emph_en_o, emph_tap_delay_o,
            emph_strength_o});
        $display("test driver config done");
        i_oslf_host_model.wr(7'h05, 16'h0005);
        wait_cyc(3);
        chk("pdown mute", 16'h0003, {14'h0, driver_powerdown_o,
            mute_o});
        rchk(7'h05, 16'h0005);
        i_oslf_host_model.wr(7'h05, 16'h0000);
        wait_cyc(3);
        chk("pdown mute", 16'h0000, {14'h0, driver_powerdown_o,
            mute_o});
        $display("test quiet control done");
        for (int r = 0; r < 5; r++) begin
            @(posedge ref_clk_i);
            rate_code_i      <= 3'(r);
            cable_reach_i    <= 8'hef - 8'(r);
            signal_present_i <= r[0];
            wait_cyc(3);
            rchk(7'h06, {8'hef - 8'(r), 4'h0, 3'(r), r[0]});
        end
        // Out-of-range reach clamps, an invalid rate code keeps the last
        @(posedge ref_clk_i);
        cable_reach_i <= 8'hff;
        rate_code_i   <= 3'h7;
        i_oslf_host_model.wr(7'h06, 16'hffff);
        rchk(7'h06, 16'hef08);
        rchk(7'h30, 16'h0000);
        $display("test status done");
        i_oslf_host_model.wr(7'h07, 16'h0001);
        i_oslf_host_model.wr(7'h05, 16'h0002);
        set_loss(1'b1, 8);
        chk("loss", 16'h0003, {14'h0, carrier_loss_o, int_o});
        chk("mute", 16'h0001, {15'h0, mute_o});
        set_loss(1'b0, 8);
        chk("loss", 16'h0003, {14'h0, carrier_loss_o, int_o});
        wait_cyc(40);
        chk("loss", 16'h0000, {14'h0, carrier_loss_o, int_o});
        chk("mute", 16'h0000, {15'h0, mute_o});
        i_oslf_host_model.wr(7'h07, 16'h0100);
        set_loss(1'b1, 100);
        set_loss(1'b0, 10);
        chk("loss", 16'h0000, {14'h0, carrier_loss_o, int_o});
        set_loss(1'b1, 3000);
        chk("loss", 16'h0000, {14'h0, carrier_loss_o, int_o});
        wait_cyc(300);
        chk("loss", 16'h0003, {14'h0, carrier_loss_o, int_o});
        set_loss(1'b0, 10);
        chk("loss", 16'h0000, {14'h0, carrier_loss_o, int_o});
        $display("test loss filter done");
        i_oslf_host_model.wr(7'h07, 16'hffff);
        i_oslf_host_model.wr(7'h08, 16'h0001);
        set_loss(1'b1, 8);
        chk("loss", 16'h0003, {14'h0, carrier_loss_o, int_o});
        set_loss(1'b0, 8);
        chk("loss", 16'h0000, {14'h0, carrier_loss_o, int_o});
        rchk(7'h08, 16'h0001);
        $display("test filter bypass done");
        give_verdict();
    end
endmodule
